// [fieldbus_slave_model.sv]
// Purpose: Behavioural model of the polled slave stations on the link side of the exchange engine.
// Assumes: Each poll moves one input word in and one output word out; delay_in sets the answer delay.
// Notes:   Released link data lines show the inverse of their last value every cycle.
`timescale 1ns/1ns
`default_nettype none
module fieldbus_slave_model (
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic  [3:0] delay_in,
  input  wire logic        poll_valid_in,
  input  wire logic  [6:0] poll_station_in,
  input  wire logic        tx_ready_in,
  input  wire logic        rx_ready_in,
  output logic             poll_done_out,
  output logic             tx_req_out,
  output logic      [11:0] tx_addr_out,
  output logic             rx_valid_out,
  output logic      [11:0] rx_addr_out,
  output logic      [15:0] rx_data_out
);
  logic [2:0] step_q;
  logic [3:0] wait_q;

  always_ff @(posedge clock_in) begin
    poll_done_out <= 1'b0;
    if (!rstn_in) begin
      {step_q, wait_q, tx_req_out, rx_valid_out} <= '0;
      {tx_addr_out, rx_addr_out, rx_data_out} <= '0;
    end else begin
      if (!rx_valid_out) begin
        {rx_addr_out, rx_data_out} <= ~{rx_addr_out, rx_data_out};
      end
      if (!tx_req_out) begin
        tx_addr_out <= ~tx_addr_out;
      end
      if (!poll_valid_in) begin
        {step_q, tx_req_out, rx_valid_out} <= 5'h00;
      end else begin
        case (step_q)
          3'h0: begin
            {rx_valid_out, rx_addr_out} <= {1'b1, 5'h00, poll_station_in};
            rx_data_out <= {1'b0, poll_station_in, 8'h5A};
            step_q <= 3'h1;
          end
          3'h1: if (rx_ready_in) begin
            {rx_valid_out, tx_req_out, tx_addr_out} <= {2'b01, 5'h00, poll_station_in};
            step_q <= 3'h2;
          end
          3'h2: if (tx_ready_in) begin
            {tx_req_out, wait_q, step_q} <= {1'b0, delay_in, 3'h3};
          end
          3'h3: if (wait_q == 4'h0) begin
            {poll_done_out, step_q} <= {1'b1, 3'h4};
          end else begin
            wait_q <= wait_q - 4'h1;
          end
          default: step_q <= 3'h0;
        endcase
      end
    end
  end
endmodule // fieldbus_slave_model
`default_nettype wire

// [fieldbus_xchg.sv]
// Purpose: Cyclic I/O exchange engine of a fieldbus class 1 master with an APB register port.
// Assumes: Link logic on clock_in; cpu_stop_error_in, systems_down_in, host_error_in are pins.
// Notes:   Buffer word w sits at byte address 4*w; input area is read-only for software.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_xchg_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Class 1 master polling up to 125 stations, 8192 bytes each of buffered input and output.
// - In a redundant setup the station count is capped at 124.
// - Received inputs live in buffer words 6144 to 10239, read by the host.
// - Outputs sent to stations come from buffer words 14336 to 18431.
// - Started flag rises once a poll has really completed after the request.
// - While running, received station data is written into the input area.
// - Dropping the start request clears the started flag and halts polling.
// - Byte swap enable exchanges word halves on sent and received data.
// - Block read and write locks keep a station's data from mixing old and new.
// - Plain buffer accesses get no protection; only the lock bits protect.
// - A setting chooses to stop or continue exchange on host stop error.
// - Redundant mode continues through host stop errors until both systems are down.
// - In redundant mode a host or own error swaps control and standby roles.
// - A station can be marked reserved and skipped without touching its parameters.
// - The engine can act as time master and send a time value to each station polled up to the end of the current cycle.
// - Station diagnostics are captured in registers and flagged to the host.
module fieldbus_xchg
  import fieldbus_xchg_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rstn_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [16:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic      [31:0] prdata_out,
  output logic             pslverr_out,
  output logic             irq_out,
  input  wire logic        cpu_stop_error_in,
  input  wire logic        systems_down_in,
  input  wire logic        host_error_in,
  input  wire logic        self_error_in,
  output logic             poll_valid_out,
  output logic       [6:0] poll_station_out,
  output logic             poll_time_out,
  output logic      [31:0] time_value_out,
  input  wire logic        poll_done_in,
  input  wire logic        tx_req_in,
  input  wire logic [11:0] tx_addr_in,
  output logic             tx_ready_out,
  output logic             tx_valid_out,
  output logic      [15:0] tx_data_out,
  input  wire logic        rx_valid_in,
  input  wire logic [11:0] rx_addr_in,
  input  wire logic [15:0] rx_data_in,
  output logic             rx_ready_out,
  input  wire logic        diag_valid_in,
  input  wire logic  [6:0] diag_station_in,
  input  wire logic [15:0] diag_word_in,
  output logic             exchange_started_ack_out,
  output logic             role_standby_out
);

  state_t     st_q;
  state_t     st_d;
  apb_req_t   req;
  logic       halt;
  logic       run;
  logic       sw_event;
  logic [6:0] stn_limit;
  logic [6:0] stn_next;
  logic       wrap;
  logic [4:0] irq_set;
  logic [15:0] tx_raw;

  function automatic logic [15:0] swap16(input logic [15:0] w, input logic en);
    swap16 = en ? {w[7:0], w[15:8]} : w;
  endfunction

  function automatic logic [6:0] clamp_stn(input logic [6:0] n, input logic [6:0] lim);
    clamp_stn = (n > lim) ? lim : n;
  endfunction

  // Turns a host word address into the offset of that word within its buffer area.
  function automatic logic [11:0] buf_idx(input logic [16:0] w, input logic [16:0] base);
    logic [16:0] off;
    off = w - base;
    buf_idx = off[11:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational view of bus request and exchange conditions.

  assign req = '{paddr: paddr_in, pwrite: pwrite_in, pwdata: pwdata_in, psel: psel_in, penable: penable_in};
  assign stn_limit = st_q.ctrl.redundant ? `MAX_STATIONS_RD : `MAX_STATIONS;
  assign halt = st_q.ctrl.redundant ? st_q.both_down_sync[1]
                                    : (st_q.cpu_err_sync[1] & st_q.ctrl.stop_on_err);
  assign run = st_q.ctrl.exchange_start_request & ~halt;
  assign sw_event = st_q.ctrl.redundant & ((st_q.host_err_sync[1] & ~st_q.host_err_prev) | self_error_in);
  assign stn_next = st_q.stn + 7'h01;
  assign wrap = (stn_next >= st_q.stations);
  assign tx_raw = st_q.out_mem[tx_addr_in];

  assign pready_out = req.psel & req.penable;
  assign prdata_out = st_q.prdata;
  assign pslverr_out = st_q.pslverr;
  assign irq_out = |(st_q.irq_stat & st_q.irq_mask);
  assign poll_valid_out = (st_q.seq == SEQ_POLL) & run & ~st_q.resv[st_q.stn];
  assign poll_station_out = st_q.stn;
  assign poll_time_out = poll_valid_out & st_q.time_pending;
  assign time_value_out = st_q.time_val;
  assign tx_ready_out = run & ~st_q.ctrl.wr_lock;
  assign rx_ready_out = run & ~st_q.ctrl.rd_lock;
  assign tx_valid_out = st_q.tx_valid;
  assign tx_data_out = st_q.tx_data;
  assign exchange_started_ack_out = st_q.exchange_started_ack;
  assign role_standby_out = st_q.role_standby;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  always_comb begin
    logic [16:0] widx;
    widx = req.paddr >> 2;
    st_d = st_q;
    irq_set = '0;
    st_d.cpu_err_sync = {st_q.cpu_err_sync[0], cpu_stop_error_in};
    st_d.both_down_sync = {st_q.both_down_sync[0], systems_down_in};
    st_d.host_err_sync = {st_q.host_err_sync[0], host_error_in};
    st_d.host_err_prev = st_q.host_err_sync[1];
    if (sw_event) begin
      st_d.role_standby = ~st_q.role_standby;
      irq_set[`IRQ_SWITCH] = 1'b1;
    end
    st_d.tx_valid = tx_req_in & tx_ready_out;
    if (tx_req_in & tx_ready_out) begin
      st_d.tx_data = swap16(tx_raw, st_q.ctrl.swap_en);
    end
    if (rx_valid_in & rx_ready_out) begin
      st_d.in_mem[rx_addr_in] = swap16(rx_data_in, st_q.ctrl.swap_en);
    end
    if (diag_valid_in) begin
      st_d.diag_stn = diag_station_in;
      st_d.diag_word = diag_word_in;
      irq_set[`IRQ_DIAG] = 1'b1;
    end
    case (st_q.seq)
      SEQ_IDLE: begin
        st_d.stn = 7'h00;
        if (run && (st_q.stations != 7'h00)) begin
          st_d.seq = SEQ_POLL;
        end
      end
      SEQ_POLL: begin
        if (!st_q.ctrl.exchange_start_request) begin
          st_d.seq = SEQ_IDLE;
        end else if (run && (st_q.resv[st_q.stn] || poll_done_in)) begin
          if (poll_done_in && !st_q.resv[st_q.stn] && !st_q.exchange_started_ack) begin
            st_d.exchange_started_ack = 1'b1;
            irq_set[`IRQ_STARTED] = 1'b1;
          end
          if (wrap) begin
            st_d.stn = 7'h00;
            st_d.time_pending = 1'b0;
            irq_set[`IRQ_CYCLE] = 1'b1;
          end else begin
            st_d.stn = stn_next;
          end
        end
      end
      default: begin
        st_d.seq = SEQ_IDLE;
      end
    endcase
    if (!st_q.ctrl.exchange_start_request) begin
      st_d.exchange_started_ack = 1'b0;
      if (st_q.exchange_started_ack) begin
        irq_set[`IRQ_STOPPED] = 1'b1;
      end
    end
    if (req.psel && !req.penable) begin
      st_d.pslverr = 1'b0;
      st_d.prdata = 32'h0000_0000;
      if (req.paddr[1:0] != 2'b00) begin
        st_d.pslverr = 1'b1;
      end else if (widx >= `IN_WORD_FIRST && widx <= `IN_WORD_LAST) begin
        st_d.prdata = {16'h0000, st_q.in_mem[buf_idx(widx, `IN_WORD_FIRST)]};
      end else if (widx >= `OUT_WORD_FIRST && widx <= `OUT_WORD_LAST) begin
        st_d.prdata = {16'h0000, st_q.out_mem[buf_idx(widx, `OUT_WORD_FIRST)]};
      end else begin
        case (req.paddr)
          `OFS_CTRL:     st_d.prdata = {25'h0000000, st_q.ctrl};
          `OFS_STATUS:   st_d.prdata = {28'h0000000, halt, run, st_q.role_standby, st_q.exchange_started_ack};
          `OFS_STATIONS: st_d.prdata = {25'h0000000, st_q.stations};
          `OFS_IRQ_STAT: st_d.prdata = {27'h0000000, st_q.irq_stat};
          `OFS_IRQ_MASK: st_d.prdata = {27'h0000000, st_q.irq_mask};
          `OFS_TIME:     st_d.prdata = st_q.time_val;
          `OFS_DIAG:     st_d.prdata = {9'h000, st_q.diag_stn, st_q.diag_word};
          `OFS_RESV0:    st_d.prdata = st_q.resv[31:0];
          `OFS_RESV0 + 17'h4: st_d.prdata = st_q.resv[63:32];
          `OFS_RESV0 + 17'h8: st_d.prdata = st_q.resv[95:64];
          `OFS_RESV0 + 17'hC: st_d.prdata = st_q.resv[127:96];
          default:       st_d.pslverr = 1'b1;
        endcase
      end
    end
    st_d.irq_stat = st_q.irq_stat;
    if (req.psel && req.penable && req.pwrite) begin
      if (widx >= `OUT_WORD_FIRST && widx <= `OUT_WORD_LAST) begin
        st_d.out_mem[buf_idx(widx, `OUT_WORD_FIRST)] = req.pwdata[15:0];
      end else begin
        case (req.paddr)
          `OFS_CTRL: begin
            st_d.ctrl = req.pwdata[6:0];
            if (req.pwdata[6]) begin
              st_d.time_pending = 1'b1;
            end
            if (req.pwdata[3]) begin
              st_d.stations = clamp_stn(st_q.stations, `MAX_STATIONS_RD);
            end
          end
          `OFS_STATIONS: st_d.stations = (|req.pwdata[31:7]) ? stn_limit
                                                             : clamp_stn(req.pwdata[6:0], stn_limit);
          `OFS_IRQ_STAT: st_d.irq_stat = st_q.irq_stat & ~req.pwdata[4:0];
          `OFS_IRQ_MASK: st_d.irq_mask = req.pwdata[4:0];
          `OFS_TIME:     st_d.time_val = req.pwdata;
          `OFS_RESV0:    st_d.resv[31:0] = req.pwdata;
          `OFS_RESV0 + 17'h4: st_d.resv[63:32] = req.pwdata;
          `OFS_RESV0 + 17'h8: st_d.resv[95:64] = req.pwdata;
          `OFS_RESV0 + 17'hC: st_d.resv[127:96] = req.pwdata;
          default: ;
        endcase
      end
    end
    st_d.irq_stat = st_d.irq_stat | irq_set;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  chk_station_cap: assert property (st_q.stations <= `MAX_STATIONS)
    else $error("station count above 125");
  chk_redund_cap: assert property (st_q.ctrl.redundant |=> st_q.stations <= `MAX_STATIONS_RD)
    else $error("redundant station count above 124");
  chk_ack_rise: assert property ($rose(st_q.exchange_started_ack) |-> $past(poll_done_in) && st_q.ctrl.exchange_start_request)
    else $error("started flag rose without completed poll");
  chk_ack_drop: assert property (!st_q.ctrl.exchange_start_request |=> !st_q.exchange_started_ack && !poll_valid_out)
    else $error("started flag held after request dropped");
  chk_swap_tx: assert property (tx_req_in && tx_ready_out && st_q.ctrl.swap_en |=> tx_valid_out && tx_data_out == {$past(tx_raw[7:0]), $past(tx_raw[15:8])})
    else $error("sent word not byte swapped");
  chk_lock_block: assert property ((st_q.ctrl.rd_lock |-> !rx_ready_out) and (st_q.ctrl.wr_lock |-> !tx_ready_out))
    else $error("locked data accepted by link");
  chk_stop_mode: assert property (!st_q.ctrl.redundant && st_q.cpu_err_sync[1] && st_q.ctrl.stop_on_err |-> !poll_valid_out && !rx_ready_out)
    else $error("exchange continued in stop mode");
  chk_redund_run: assert property (st_q.ctrl.redundant && !st_q.both_down_sync[1] |-> !halt)
    else $error("redundant exchange halted early");
  chk_role_swap: assert property (sw_event |=> st_q.role_standby != $past(st_q.role_standby) && st_q.irq_stat[`IRQ_SWITCH])
    else $error("role not swapped on error");
  chk_resv_skip: assert property (poll_valid_out |-> !st_q.resv[st_q.stn])
    else $error("reserved station polled");
  chk_diag_capture: assert property (diag_valid_in |=> st_q.diag_stn == $past(diag_station_in) && st_q.irq_stat[`IRQ_DIAG])
    else $error("diagnostic not captured");
  chk_rx_store: assert property (rx_valid_in && rx_ready_out && !st_q.ctrl.swap_en |=> st_q.in_mem[$past(rx_addr_in)] == $past(rx_data_in))
    else $error("received word not stored");
  chk_swap_rx: assert property (rx_valid_in && rx_ready_out && st_q.ctrl.swap_en |=> st_q.in_mem[$past(rx_addr_in)] == {$past(rx_data_in[7:0]), $past(rx_data_in[15:8])})
    else $error("received word not byte swapped");
  chk_tx_plain: assert property (tx_req_in && tx_ready_out && !st_q.ctrl.swap_en |=> tx_valid_out && tx_data_out == $past(tx_raw))
    else $error("sent word differs from output area");
  chk_halt_link: assert property (halt |-> !rx_ready_out && !tx_ready_out && !poll_valid_out)
    else $error("link served while halted");
  chk_stop_flag: assert property (st_q.exchange_started_ack && !st_q.ctrl.exchange_start_request |=> st_q.irq_stat[`IRQ_STOPPED] && !st_q.exchange_started_ack)
    else $error("stop not flagged");
  chk_zero_wait: assert property (psel_in && penable_in |-> pready_out)
    else $error("access phase stalled");
  chk_misalign: assert property (psel_in && !penable_in && paddr_in[1:0] != 2'b00 |=> pslverr_out)
    else $error("misaligned access not refused");
  chk_station_wr: assert property (psel_in && penable_in && pwrite_in && paddr_in == `OFS_STATIONS && pwdata_in > 32'h7D |=> st_q.stations == $past(stn_limit))
    else $error("station count not clamped");

endmodule // fieldbus_xchg
`default_nettype wire

// [fieldbus_xchg_consts.svh]
// Purpose: Offsets, field positions, reset values and limits of the I/O exchange engine.
// Assumes: Byte addresses on a 32-bit APB bus, one register or buffer word per aligned word.
// Notes:   Definitions only.
`ifndef FIELDBUS_XCHG_CONSTS_SVH
`define FIELDBUS_XCHG_CONSTS_SVH

`define OFS_CTRL        17'h00000
`define OFS_STATUS      17'h00004
`define OFS_STATIONS    17'h00008
`define OFS_IRQ_STAT    17'h0000C
`define OFS_IRQ_MASK    17'h00010
`define OFS_TIME        17'h00014
`define OFS_DIAG        17'h00018
`define OFS_RESV0       17'h00020
`define IN_WORD_FIRST   17'd6144
`define IN_WORD_LAST    17'd10239
`define OUT_WORD_FIRST  17'd14336
`define OUT_WORD_LAST   17'd18431

`define MAX_STATIONS    7'd125
`define MAX_STATIONS_RD 7'd124
`define BUF_WORDS       4096

`define IRQ_STARTED     0
`define IRQ_STOPPED     1
`define IRQ_CYCLE       2
`define IRQ_DIAG        3
`define IRQ_SWITCH      4
`define IRQ_BITS        5

`define RST_CTRL        8'h00
`define RST_STATIONS    7'h00
`define RST_IRQ         5'h00

`endif

// [fieldbus_xchg_pkg.sv]
// Purpose: Types shared by the I/O exchange engine.
// Assumes: Constants come from the header.
// Notes:   The whole engine state is one packed struct.
`default_nettype none
package fieldbus_xchg_pkg;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_POLL
  } seq_state_t;

  typedef struct packed {
    logic time_req;
    logic wr_lock;
    logic rd_lock;
    logic redundant;
    logic stop_on_err;
    logic swap_en;
    logic exchange_start_request;
  } ctrl_t;

  typedef struct packed {
    logic [16:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } apb_req_t;

  typedef struct packed {
    logic [4095:0][15:0] in_mem;
    logic [4095:0][15:0] out_mem;
    ctrl_t               ctrl;
    logic [6:0]          stations;
    logic [127:0]        resv;
    logic [4:0]          irq_stat;
    logic [4:0]          irq_mask;
    logic [31:0]         time_val;
    logic [6:0]          diag_stn;
    logic [15:0]         diag_word;
    seq_state_t          seq;
    logic [6:0]          stn;
    logic                exchange_started_ack;
    logic                time_pending;
    logic                role_standby;
    logic [1:0]          cpu_err_sync;
    logic [1:0]          both_down_sync;
    logic [1:0]          host_err_sync;
    logic                host_err_prev;
    logic [15:0]         tx_data;
    logic                tx_valid;
    logic [31:0]         prdata;
    logic                pslverr;
  } state_t;

endpackage
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench of the I/O exchange engine through APB and the station model.
// Assumes: Zero-wait APB slave; three stations polled.
// Notes:   Buffer word w is reached at byte address 4*w.
`timescale 1ns/1ns
`default_nettype none
`include "fieldbus_xchg_consts.svh"
module tb;
  logic        clock_in, rstn_in, psel, penable, pwrite, pready, pslverr, irq, cpu_stop, sys_down;
  logic        host_err, self_err, poll_valid, poll_time, poll_done, tx_req, tx_ready, tx_valid;
  logic        rx_valid, rx_ready, diag_valid, ack, standby, watch, seen_resv, rerr;
  logic [16:0] paddr;
  logic [31:0] pwdata, prdata, time_value, rdat;
  logic [11:0] tx_addr, rx_addr;
  logic [15:0] tx_data, rx_data, diag_word;
  logic  [6:0] poll_station, diag_stn;
  logic  [3:0] delay;
  logic [15:0] tx_seen [0:127];
  int          mismatches, compares, n;

  fieldbus_xchg i_fieldbus_xchg (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .irq_out(irq), .cpu_stop_error_in(cpu_stop), .systems_down_in(sys_down),
    .host_error_in(host_err), .self_error_in(self_err), .poll_valid_out(poll_valid),
    .poll_station_out(poll_station), .poll_time_out(poll_time), .time_value_out(time_value),
    .poll_done_in(poll_done), .tx_req_in(tx_req), .tx_addr_in(tx_addr), .tx_ready_out(tx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .rx_valid_in(rx_valid), .rx_addr_in(rx_addr),
    .rx_data_in(rx_data), .rx_ready_out(rx_ready), .diag_valid_in(diag_valid), .diag_station_in(diag_stn),
    .diag_word_in(diag_word), .exchange_started_ack_out(ack), .role_standby_out(standby));
  fieldbus_slave_model i_fieldbus_slave_model (.clock_in(clock_in), .rstn_in(rstn_in), .delay_in(delay),
    .poll_valid_in(poll_valid), .poll_station_in(poll_station), .tx_ready_in(tx_ready),
    .rx_ready_in(rx_ready), .poll_done_out(poll_done), .tx_req_out(tx_req), .tx_addr_out(tx_addr),
    .rx_valid_out(rx_valid), .rx_addr_out(rx_addr), .rx_data_out(rx_data));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected pin at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [16:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clock_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (k >= 50) begin
      mismatches++;
      finish_test();
    end
  endtask
  task automatic rd_chk(input logic [16:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check_val(rdat, e);
  endtask
  task automatic wait_reg(input logic [16:0] a, input logic [31:0] m, input logic [31:0] e);
    int k;
    apb(1'b0, a, 32'h0);
    for (k = 0; k < 400 && (rdat & m) !== e; k++) apb(1'b0, a, 32'h0);
    check_val(rdat & m, e);
    if (k == 400) finish_test();
  endtask
  task automatic cyc_wait;
    apb(1'b1, `OFS_IRQ_STAT, 32'h1F);
    wait_reg(`OFS_IRQ_STAT, 32'h4, 32'h4);
  endtask
  function automatic logic [16:0] bufa(input int w);
    return 17'(4 * w);
  endfunction
  function automatic logic [31:0] swp(input logic [15:0] w, input logic sw);
    return sw ? {16'h0, w[7:0], w[15:8]} : {16'h0, w};
  endfunction
  task automatic cycle_check(input logic sw);
    cyc_wait();
    cyc_wait();
    for (int s = 0; s < 3; s++) begin
      rd_chk(bufa(`IN_WORD_FIRST + s), swp({1'b0, 7'(s), 8'h5A}, sw));
      check_val({16'h0, tx_seen[s]}, swp(16'h3C00 | 16'(s), sw));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in) begin
    if (tx_valid === 1'b1) tx_seen[poll_station] <= tx_data;
    if (watch && poll_valid === 1'b1 && poll_station === 7'h01) seen_resv <= 1'b1;
  end
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end
  initial begin
    {rstn_in, psel, penable, pwrite, paddr, pwdata, cpu_stop, sys_down, host_err, self_err} = '0;
    {diag_valid, diag_stn, diag_word, watch, seen_resv, delay} = {26'h0, 4'h2};
    mismatches = 0;
    compares = 0;
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    rd_chk(`OFS_STATUS, 32'h0);
    apb(1'b0, 17'h0001C, 32'h0);
    check_bit(rerr, 1'b1);
    apb(1'b1, 17'h00002, 32'h1);
    check_bit(rerr, 1'b1);
    apb(1'b1, `OFS_STATIONS, 32'hC8);
    rd_chk(`OFS_STATIONS, {25'h0, `MAX_STATIONS});
    apb(1'b1, `OFS_CTRL, 32'h08);
    rd_chk(`OFS_STATIONS, {25'h0, `MAX_STATIONS_RD});
    apb(1'b1, `OFS_CTRL, 32'h00);
    apb(1'b1, `OFS_STATIONS, 32'h03);
    for (int s = 0; s < 3; s++) apb(1'b1, bufa(`OUT_WORD_FIRST + s), 32'hFFFF3C00 | 32'(s));
    rd_chk(bufa(`OUT_WORD_FIRST), 32'h3C00);
    apb(1'b1, bufa(`IN_WORD_LAST), 32'h1234);
    rd_chk(bufa(`IN_WORD_LAST), 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h01);
    check_bit(ack, 1'b0);
    wait_reg(`OFS_STATUS, 32'h1, 32'h1);
    wait_reg(`OFS_IRQ_STAT, 32'h1, 32'h1);
    cycle_check(1'b0);
    delay <= 4'h9;
    apb(1'b1, `OFS_CTRL, 32'h03);
    cycle_check(1'b1);
    apb(1'b1, `OFS_CTRL, 32'h23);
    repeat (40) @(posedge clock_in);
    check_bit(tx_ready, 1'b0);
    check_bit(poll_valid, 1'b1);
    apb(1'b1, `OFS_CTRL, 32'h13);
    repeat (40) @(posedge clock_in);
    check_bit(rx_ready, 1'b0);
    rd_chk(bufa(`IN_WORD_FIRST), 32'h5A00);
    apb(1'b1, `OFS_CTRL, 32'h03);
    apb(1'b1, `OFS_RESV0, 32'h2);
    cyc_wait();
    watch <= 1'b1;
    cyc_wait();
    watch <= 1'b0;
    check_bit(seen_resv, 1'b0);
    rd_chk(`OFS_STATIONS, 32'h03);
    apb(1'b1, `OFS_RESV0, 32'h0);
    apb(1'b1, `OFS_TIME, 32'h12345678);
    apb(1'b1, `OFS_CTRL, 32'h43);
    for (n = 0; n < 1000 && poll_time !== 1'b1; n++) @(posedge clock_in);
    check_bit(poll_time, 1'b1);
    check_val(time_value, 32'h12345678);
    if (n == 1000) finish_test();
    apb(1'b1, `OFS_CTRL, 32'h03);
    {diag_valid, diag_stn, diag_word} <= {1'b1, 7'h05, 16'hBEEF};
    @(posedge clock_in);
    diag_valid <= 1'b0;
    wait_reg(`OFS_IRQ_STAT, 32'h8, 32'h8);
    rd_chk(`OFS_DIAG, 32'h0005BEEF);
    check_bit(irq, 1'b0);
    apb(1'b1, `OFS_IRQ_MASK, 32'h8);
    #1 check_bit(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_STAT, 32'h8);
    #1 check_bit(irq, 1'b0);
    apb(1'b1, `OFS_CTRL, 32'h0B);
    self_err <= 1'b1;
    @(posedge clock_in);
    self_err <= 1'b0;
    wait_reg(`OFS_STATUS, 32'h2, 32'h2);
    wait_reg(`OFS_IRQ_STAT, 32'h10, 32'h10);
    host_err <= 1'b1;
    repeat (5) @(posedge clock_in);
    host_err <= 1'b0;
    wait_reg(`OFS_STATUS, 32'h2, 32'h0);
    apb(1'b1, `OFS_CTRL, 32'h0F);
    cpu_stop <= 1'b1;
    repeat (8) @(posedge clock_in);
    wait_reg(`OFS_STATUS, 32'h8, 32'h0);
    sys_down <= 1'b1;
    wait_reg(`OFS_STATUS, 32'h8, 32'h8);
    {sys_down, cpu_stop} <= 2'b00;
    apb(1'b1, `OFS_CTRL, 32'h07);
    wait_reg(`OFS_STATUS, 32'h8, 32'h0);
    cpu_stop <= 1'b1;
    wait_reg(`OFS_STATUS, 32'h8, 32'h8);
    check_bit(poll_valid, 1'b0);
    apb(1'b1, `OFS_CTRL, 32'h03);
    repeat (8) @(posedge clock_in);
    wait_reg(`OFS_STATUS, 32'h8, 32'h0);
    cpu_stop <= 1'b0;
    apb(1'b1, `OFS_CTRL, 32'h00);
    wait_reg(`OFS_STATUS, 32'h1, 32'h0);
    wait_reg(`OFS_IRQ_STAT, 32'h2, 32'h2);
    check_bit(poll_valid, 1'b0);
    check_bit(ack, 1'b0);
    finish_test();
  end
endmodule // tb
`default_nettype wire
